// ---- core/msdr_top.sv ----
// The address-and-strobe port was decided locally.
`default_nettype none
// Behaviour
// - accel X sample, high byte at 0x3B, low byte at 0x3C.
// - accel Y sample, high byte at 0x3D, low byte at 0x3E.
// - accel Z sample, high byte at 0x3F, low byte at 0x40.
// - temperature result, high byte at 0x41, low byte at 0x42.
// - rate X result, high byte at 0x43, low byte at 0x44.
// - rate Y result, high byte at 0x45, low byte at 0x46.
// - rate Z result, high byte at 0x47, low byte at 0x48.
// - bit 2 write restarts rate path, rate results kept.
// - bit 1 write restarts accel path, accel results kept.
// - bit 0 write restarts temperature path, temperature result kept.
// - control bit 7 enables motion comparison; clear means no comparison.
// - mode bit 6 one compares each sample with the previous one.
// - mode bit zero stores first sample as reference, compares later samples.
// - full restart restarts all three paths and clears all results.
// - motion on X, Y, Z sets status flag bit 7, 6, 5.
module msdr_top (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic [msdr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [msdr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [msdr_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        acc_valid,
    input  wire logic [msdr_pkg::SMP_W-1:0]  acc_x,
    input  wire logic [msdr_pkg::SMP_W-1:0]  acc_y,
    input  wire logic [msdr_pkg::SMP_W-1:0]  acc_z,
    input  wire logic                        tmp_valid,
    input  wire logic [msdr_pkg::SMP_W-1:0]  tmp_val,
    input  wire logic                        rate_valid,
    input  wire logic [msdr_pkg::SMP_W-1:0]  rate_x,
    input  wire logic [msdr_pkg::SMP_W-1:0]  rate_y,
    input  wire logic [msdr_pkg::SMP_W-1:0]  rate_z,
    output logic                             rate_path_restart,
    output logic                             acc_path_restart,
    output logic                             tmp_path_restart,
    output logic                             irq
);
    import msdr_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [15:0] ax;
        logic [15:0] ay;
        logic [15:0] az;
        logic [15:0] tv;
        logic [15:0] gx;
        logic [15:0] gy;
        logic [15:0] gz;
        logic [15:0] refx;
        logic [15:0] refy;
        logic [15:0] refz;
        logic        ref_ok;
        logic [7:0]  mot_ctl;
        logic [7:0]  thr;
        logic [7:0]  stat;
        logic [7:0]  mask;
        logic [7:0]  rdata;
        logic        rst_g;
        logic        rst_a;
        logic        rst_t;
        logic        irq;
    } msdr_state_t;

    msdr_state_t st_r;
    msdr_state_t st_nxt;

    // magnitude of a signed difference, one bit wider so it never wraps
    function automatic logic [16:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] d;
        d = $signed({a[15], a}) - $signed({b[15], b});
        return d[16] ? 17'(-d) : 17'(d);
    endfunction

    logic        wr_path;
    logic        wr_full;
    logic        full_go;
    logic [7:0]  new_flags;
    logic        moved_x;
    logic        moved_y;
    logic        moved_z;

    // ==========================================================
    // next state
    always_comb begin
        st_nxt   = st_r;
        wr_path  = reg_wr && (reg_addr == OFS_PATH_RST);
        wr_full  = reg_wr && (reg_addr == OFS_FULL_RST);
        full_go  = wr_full && reg_wdata[BIT_FULL_RST];
        moved_x  = abs_diff(acc_x, st_r.refx) > {9'h000, st_r.thr};
        moved_y  = abs_diff(acc_y, st_r.refy) > {9'h000, st_r.thr};
        moved_z  = abs_diff(acc_z, st_r.refz) > {9'h000, st_r.thr};
        new_flags = RST_BYTE;

        // restart strobes are one-cycle pulses
        st_nxt.rst_g = (wr_path && reg_wdata[BIT_RST_GYRO]) || full_go;
        st_nxt.rst_a = (wr_path && reg_wdata[BIT_RST_ACC]) || full_go;
        st_nxt.rst_t = (wr_path && reg_wdata[BIT_RST_TMP]) || full_go;

        // results latch fresh samples; only the full restart write reaches them
        if (acc_valid) begin
            st_nxt.ax = acc_x;
            st_nxt.ay = acc_y;
            st_nxt.az = acc_z;
        end
        if (tmp_valid) begin
            st_nxt.tv = tmp_val;
        end
        if (rate_valid) begin
            st_nxt.gx = rate_x;
            st_nxt.gy = rate_y;
            st_nxt.gz = rate_z;
        end

        // motion comparison against the held reference
        if (!st_r.mot_ctl[BIT_MOT_EN]) begin
            st_nxt.ref_ok = 1'b0;
        end else if (acc_valid) begin
            if (st_r.ref_ok) begin
                new_flags[BIT_FLAG_X] = moved_x;
                new_flags[BIT_FLAG_Y] = moved_y;
                new_flags[BIT_FLAG_Z] = moved_z;
            end
            // previous-sample mode refreshes the reference each time,
            // initial-sample mode only takes the first one
            if (!st_r.ref_ok || st_r.mot_ctl[BIT_MOT_PREV]) begin
                st_nxt.refx   = acc_x;
                st_nxt.refy   = acc_y;
                st_nxt.refz   = acc_z;
                st_nxt.ref_ok = 1'b1;
            end
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_MOT_CTL: begin
                    st_nxt.mot_ctl = reg_wdata & MOT_CTL_MASK;
                    // a new mode or enable restarts the reference capture
                    st_nxt.ref_ok  = 1'b0;
                end
                OFS_MOT_THR:  st_nxt.thr  = reg_wdata;
                OFS_INT_MASK: st_nxt.mask = reg_wdata & FLAG_MASK;
                default: ;
            endcase
        end

        // write-one-to-clear, a new event in the same cycle wins
        if (reg_wr && reg_addr == OFS_INT_STAT) begin
            st_nxt.stat = st_r.stat & ~reg_wdata;
        end
        st_nxt.stat = (st_nxt.stat | new_flags) & FLAG_MASK;

        // accel path restart drops the motion reference, results stay
        if (st_nxt.rst_a) begin
            st_nxt.ref_ok = 1'b0;
        end

        // full restart wipes every result; beats a same-cycle sample
        if (full_go) begin
            st_nxt.ax     = RST_SAMPLE;
            st_nxt.ay     = RST_SAMPLE;
            st_nxt.az     = RST_SAMPLE;
            st_nxt.tv     = RST_SAMPLE;
            st_nxt.gx     = RST_SAMPLE;
            st_nxt.gy     = RST_SAMPLE;
            st_nxt.gz     = RST_SAMPLE;
            st_nxt.refx   = RST_SAMPLE;
            st_nxt.refy   = RST_SAMPLE;
            st_nxt.refz   = RST_SAMPLE;
            st_nxt.ref_ok = 1'b0;
        end

        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

        // read data, valid in the cycle after the strobe only
        st_nxt.rdata = RST_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_ACC_XH:   st_nxt.rdata = st_r.ax[15:8];
                OFS_ACC_XL:   st_nxt.rdata = st_r.ax[7:0];
                OFS_ACC_YH:   st_nxt.rdata = st_r.ay[15:8];
                OFS_ACC_YL:   st_nxt.rdata = st_r.ay[7:0];
                OFS_ACC_ZH:   st_nxt.rdata = st_r.az[15:8];
                OFS_ACC_ZL:   st_nxt.rdata = st_r.az[7:0];
                OFS_TMP_H:    st_nxt.rdata = st_r.tv[15:8];
                OFS_TMP_L:    st_nxt.rdata = st_r.tv[7:0];
                OFS_RATE_XH:  st_nxt.rdata = st_r.gx[15:8];
                OFS_RATE_XL:  st_nxt.rdata = st_r.gx[7:0];
                OFS_RATE_YH:  st_nxt.rdata = st_r.gy[15:8];
                OFS_RATE_YL:  st_nxt.rdata = st_r.gy[7:0];
                OFS_RATE_ZH:  st_nxt.rdata = st_r.gz[15:8];
                OFS_RATE_ZL:  st_nxt.rdata = st_r.gz[7:0];
                OFS_MOT_CTL:  st_nxt.rdata = st_r.mot_ctl;
                OFS_MOT_THR:  st_nxt.rdata = st_r.thr;
                OFS_INT_MASK: st_nxt.rdata = st_r.mask;
                OFS_INT_STAT: st_nxt.rdata = st_r.stat;
                // restart bits are strobes and read back as zero
                default:      st_nxt.rdata = RST_BYTE;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r      <= '0;
            st_r.thr  <= RST_THR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata         = st_r.rdata;
    assign rate_path_restart = st_r.rst_g;
    assign acc_path_restart  = st_r.rst_a;
    assign tmp_path_restart  = st_r.rst_t;
    assign irq               = st_r.irq;
endmodule
`default_nettype wire

// ---- core/msdr_pkg.sv ----
`default_nettype none
package msdr_pkg;
    // ==========================================================
    // bus widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SMP_W  = 16;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_ACC_XH   = 8'h3B;
    localparam logic [7:0] OFS_ACC_XL   = 8'h3C;
    localparam logic [7:0] OFS_ACC_YH   = 8'h3D;
    localparam logic [7:0] OFS_ACC_YL   = 8'h3E;
    localparam logic [7:0] OFS_ACC_ZH   = 8'h3F;
    localparam logic [7:0] OFS_ACC_ZL   = 8'h40;
    localparam logic [7:0] OFS_TMP_H    = 8'h41;
    localparam logic [7:0] OFS_TMP_L    = 8'h42;
    localparam logic [7:0] OFS_RATE_XH  = 8'h43;
    localparam logic [7:0] OFS_RATE_XL  = 8'h44;
    localparam logic [7:0] OFS_RATE_YH  = 8'h45;
    localparam logic [7:0] OFS_RATE_YL  = 8'h46;
    localparam logic [7:0] OFS_RATE_ZH  = 8'h47;
    localparam logic [7:0] OFS_RATE_ZL  = 8'h48;
    localparam logic [7:0] OFS_PATH_RST = 8'h68;
    localparam logic [7:0] OFS_MOT_CTL  = 8'h69;
    localparam logic [7:0] OFS_FULL_RST = 8'h6A;
    localparam logic [7:0] OFS_INT_MASK = 8'h38;
    localparam logic [7:0] OFS_INT_STAT = 8'h3A;
    localparam logic [7:0] OFS_MOT_THR  = 8'h1F;

    // ==========================================================
    // field positions
    localparam int unsigned BIT_RST_GYRO = 2;
    localparam int unsigned BIT_RST_ACC  = 1;
    localparam int unsigned BIT_RST_TMP  = 0;
    localparam int unsigned BIT_MOT_EN   = 7;
    localparam int unsigned BIT_MOT_PREV = 6;
    localparam int unsigned BIT_FULL_RST = 0;
    localparam int unsigned BIT_FLAG_X   = 7;
    localparam int unsigned BIT_FLAG_Y   = 6;
    localparam int unsigned BIT_FLAG_Z   = 5;

    // ==========================================================
    // reset values and masks
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_SAMPLE = 16'h0000;
    localparam logic [7:0]  RST_THR    = 8'h10;
    localparam logic [7:0]  MOT_CTL_MASK = 8'hC0;
    localparam logic [7:0]  FLAG_MASK    = 8'hE0;
endpackage
`default_nettype wire

// ---- tb/msdr_top_assertions.sv ----
`default_nettype none
module msdr_top_assertions import msdr_pkg::*; (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       acc_valid,
    input wire logic       rate_path_restart,
    input wire logic       acc_path_restart,
    input wire logic       tmp_path_restart,
    input wire logic       irq
);
    // ==========
    // port checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wp, wa, wf;
    assign wp = reg_wr && reg_addr == OFS_PATH_RST;
    assign wa = wp && reg_wdata[BIT_RST_ACC];
    assign wf = reg_wr && reg_addr == OFS_FULL_RST && reg_wdata[BIT_FULL_RST];
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    // a strobe right behind the first may legally stretch the pulse
    property p_rate; wp && reg_wdata[BIT_RST_GYRO] |=> rate_path_restart
        ##1 (!rate_path_restart || $past(wp && reg_wdata[BIT_RST_GYRO]) || $past(wf)); endproperty
    a_rate: assert property (p_rate) else $error("rate restart pulse wrong");
    property p_acc; wa |=> acc_path_restart ##1 (!acc_path_restart || $past(wa) || $past(wf));
    endproperty
    a_acc: assert property (p_acc) else $error("accel restart pulse wrong");
    property p_tmp; wp && reg_wdata[BIT_RST_TMP] |=> tmp_path_restart
        ##1 (!tmp_path_restart || $past(wp && reg_wdata[BIT_RST_TMP]) || $past(wf)); endproperty
    a_tmp: assert property (p_tmp) else $error("temp restart pulse wrong");
    property p_full; wf |=> rate_path_restart && acc_path_restart && tmp_path_restart; endproperty
    a_full: assert property (p_full) else $error("full restart misses a path");
    property p_cause; acc_path_restart |-> $past(wf) || $past(wa); endproperty
    a_cause: assert property (p_cause) else $error("accel restart without write");
    // a fresh sample after the restart may legally refill the result
    property p_full_clr; wf ##1 !acc_valid ##1 (reg_rd && reg_addr == OFS_ACC_XH)
        |=> reg_rdata == 8'h00; endproperty
    a_full_clr: assert property (p_full_clr) else $error("result kept after full restart");
    property p_irq_clr; irq && reg_wr && reg_addr == OFS_INT_STAT && reg_wdata == 8'hFF && !acc_valid
        |=> !irq; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq stays after clear");
    c_full: cover property (wf);
    c_irq: cover property ($rose(irq));
    c_stat: cover property (reg_rd && reg_addr == OFS_INT_STAT);
endmodule
bind msdr_top msdr_top_assertions u_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .acc_valid, .rate_path_restart, .acc_path_restart, .tmp_path_restart, .irq);
`default_nettype wire

// ---- tb/msdr_host.sv ----
`default_nettype none
module msdr_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // host bus cycles, strobes one cycle, no wait states
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // released data must not look valid
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/motion_sensor_data_regs_tb.sv ----
`default_nettype none
module motion_sensor_data_regs_tb import msdr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // bench
    logic        clk = 1'b0, nrst = 1'b0, rd_d = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, acc_valid, tmp_valid, rate_valid, irq;
    logic [15:0] smp [7];
    logic [7:0]  exp_q [$];
    int          bad_count = 0, n_tests = 0;
    always #10 clk = ~clk;
    msdr_top u_msdr_top (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .acc_valid, .acc_x(smp[0]), .acc_y(smp[1]), .acc_z(smp[2]), .tmp_valid, .tmp_val(smp[3]),
        .rate_valid, .rate_x(smp[4]), .rate_y(smp[5]), .rate_z(smp[6]), .irq,
        .rate_path_restart(), .acc_path_restart(), .tmp_path_restart());
    msdr_host u_msdr_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_msdr_host.rd(a);
    endtask
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1) chk(reg_rdata, exp_q.pop_front());
    end
    task automatic rd_all(input logic clr);
        for (int i = 0; i < 14; i++)
            rd(OFS_ACC_XH + 8'(i), clr ? 8'h00 : (i[0] ? smp[i/2][7:0] : smp[i/2][15:8]));
    endtask
    task automatic samp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge clk);
        smp[0] <= x;
        smp[1] <= y;
        smp[2] <= z;
        acc_valid <= 1'b1;
        @(posedge clk);
        acc_valid <= 1'b0;
    endtask
    task automatic stat(input logic [7:0] e, input logic [7:0] m);
        rd(OFS_INT_STAT, e);
        @(negedge clk);
        chk({7'h00, irq}, {7'h00, (e & m) != 8'h00});
        u_msdr_host.wr(OFS_INT_STAT, 8'hFF);
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
    endtask
    // y sits exactly on the threshold, so only a strict compare leaves it quiet
    task automatic mot(input logic [7:0] ctl, input logic [7:0] m, input logic [7:0] e2,
                       input logic [7:0] e3);
        u_msdr_host.wr(OFS_INT_MASK, m);
        u_msdr_host.wr(OFS_MOT_CTL, ctl);
        samp(16'h0000, 16'h0000, 16'h0000);
        samp(16'h0011, 16'h0010, 16'hFFEF);
        stat(e2, m);
        samp(16'h0011, 16'h0021, 16'hFFEF);
        stat(e3, m);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {acc_valid, tmp_valid, rate_valid} = 3'b000;
        foreach (smp[i]) smp[i] = 16'h0000;
        void'($urandom(39));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_all(1'b1);
        @(posedge clk);
        foreach (smp[i]) smp[i] <= 16'($urandom);
        {acc_valid, tmp_valid, rate_valid} <= 3'b111;
        @(posedge clk);
        {acc_valid, tmp_valid, rate_valid} <= 3'b000;
        rd_all(1'b0);
        for (int i = 0; i < 14; i++) u_msdr_host.wr(OFS_ACC_XH + 8'(i), 8'($urandom));
        rd_all(1'b0);
        u_msdr_host.wr(OFS_PATH_RST, 8'h07);
        rd_all(1'b0);
        u_msdr_host.wr(OFS_MOT_CTL, 8'hFF);
        rd(OFS_MOT_CTL, MOT_CTL_MASK);
        rd(8'h00, 8'h00);
        mot(8'hC0, 8'hE0, 8'hA0, 8'h40);
        mot(8'h80, 8'h40, 8'hA0, 8'hE0);
        mot(8'h00, 8'hE0, 8'h00, 8'h00);
        u_msdr_host.wr(OFS_FULL_RST, 8'h01);
        rd_all(1'b1);
        repeat (2) @(posedge clk);
        end_sim;
    end
    initial begin
        #100us;
        bad_count++;
        end_sim;
    end
endmodule
`default_nettype wire
